/* pwg_pkg.sv */
// package of constants and carrier types for the wake enable gating block
//
// Overview of operation
// - pin wake enable register at index 0A
// - misc wake enable register at index 0B
// - both enables load 00 on standby reset
// - wake needs enable, status and global enable
// - disabled source still sets its status bit
// - pin enable bits 0..7 map pins 50..57
// - pin enables survive main, soft, bus resets
// - misc enables survive main, soft, bus resets
// - misc bit0 battery, bit1 reserved, bits2-3 pins
// - misc bits 4,5,6 mouse, key, power button
// - misc bit7 holds power fail recovery enable
// - disabled misc source status still records event
// - status bits clear on write one only
package pwg_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register indices; byte address is four times the index
  localparam logic [7:0] PWG_IDX_GPIO_EN   = 8'h0A; // pin wake enable
  localparam logic [7:0] PWG_IDX_MISC_EN   = 8'h0B; // misc wake enable
  localparam logic [7:0] PWG_IDX_GPIO_STS  = 8'h10; // pin wake status
  localparam logic [7:0] PWG_IDX_MISC_STS  = 8'h11; // misc wake status
  localparam logic [7:0] PWG_IDX_GLOBAL_EN = 8'h12; // global wake enable
  localparam int         PWG_ADDR_W        = 12;    // decoded address width

  //////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic [7:0] PWG_EN_RST     = 8'h00; // both enable registers
  localparam logic [7:0] PWG_STS_RST    = 8'h00; // both status registers
  localparam logic       PWG_GLOBAL_RST = 1'b0;  // global enable

  //////////////////////////////////////////////////////////////////////////
  // misc register field positions
  localparam int PWG_MISC_LOW_BATTERY_ENABLE  = 0; // low battery
  localparam int PWG_MISC_RSVD     = 1; // reserved, reads zero
  localparam int PWG_MISC_GPIO_PIN_60_WAKE     = 2; // pin 60
  localparam int PWG_MISC_GPIO_PIN_61_WAKE     = 3; // pin 61
  localparam int PWG_MISC_MOUSE    = 4; // mouse click wake
  localparam int PWG_MISC_KEY      = 5; // key wake
  localparam int PWG_MISC_PWR_BTN  = 6; // power button wake
  localparam int PWG_MISC_PFR      = 7; // power fail recovery enable
  // misc bits that are real wake sources (0,2..6)
  localparam logic [7:0] PWG_MISC_SRC_MASK = 8'h7D;
  // writable misc enable bits with and without the recovery bit
  localparam logic [7:0] PWG_MISC_WR_PFR   = 8'hFD;
  localparam logic [7:0] PWG_MISC_WR_NOPFR = 8'h7D;

  //////////////////////////////////////////////////////////////////////////
  // carrier types
  typedef struct packed {
    logic                  psel;    // slave select
    logic                  penable; // access phase
    logic                  pwrite;  // write direction
    logic [PWG_ADDR_W-1:0] paddr;   // byte address
    logic [31:0]           pwdata;  // write data
  } pwg_apb_req_type;

  typedef struct packed {
    logic [7:0] gpio; // pins 50..57 event levels
    logic [7:0] misc; // misc source events, same bit layout
  } pwg_event_type;

endpackage : pwg_pkg

/* pwg_wake_gate.sv */
// wake enable gating block with its apb register file
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module pwg_wake_gate #(
  parameter bit HAS_PFR = 1'b1 // variant carries the recovery enable bit
) (
  // clock and standby-power reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  // apb slave
  input  wire pwg_pkg::pwg_apb_req_type apb_req,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // wake source events
  input  wire pwg_pkg::pwg_event_type   wake_event,
  // wake output and enables seen by other logic
  output logic                          wake_out_n,
  output logic                          power_fail_recovery_enable
);
  import pwg_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]  gpio_wake_enable_ff;  // pins 50..57 enables
  logic [7:0]  misc_wake_enable_ff;  // misc enables
  logic [7:0]  gpio_wake_status_ff;  // sticky pin status
  logic [7:0]  misc_wake_status_ff;  // sticky misc status
  logic        global_wake_enable_ff; // global gate
  logic        wake_out_n_ff;        // registered wake pin
  logic [31:0] prdata_ff;            // read data
  logic        pslverr_ff;           // unmapped flag

  //////////////////////////////////////////////////////////////////////////
  // address decode
  wire [PWG_ADDR_W-3:0] reg_idx = apb_req.paddr[PWG_ADDR_W-1:2]; // word index
  // index compare on the word index, widened to the same size
  wire [PWG_ADDR_W-3:0] idx_gpio_en  = (PWG_ADDR_W-2)'(PWG_IDX_GPIO_EN);
  wire [PWG_ADDR_W-3:0] idx_misc_en  = (PWG_ADDR_W-2)'(PWG_IDX_MISC_EN);
  wire [PWG_ADDR_W-3:0] idx_gpio_sts = (PWG_ADDR_W-2)'(PWG_IDX_GPIO_STS);
  wire [PWG_ADDR_W-3:0] idx_misc_sts = (PWG_ADDR_W-2)'(PWG_IDX_MISC_STS);
  wire [PWG_ADDR_W-3:0] idx_global   = (PWG_ADDR_W-2)'(PWG_IDX_GLOBAL_EN);
  wire sel_gpio_en  = (reg_idx == idx_gpio_en);
  wire sel_misc_en  = (reg_idx == idx_misc_en);
  wire sel_gpio_sts = (reg_idx == idx_gpio_sts);
  wire sel_misc_sts = (reg_idx == idx_misc_sts);
  wire sel_global   = (reg_idx == idx_global);
  wire addr_mapped  = sel_gpio_en | sel_misc_en | sel_gpio_sts
                    | sel_misc_sts | sel_global;

  // phases: setup loads read data, access commits writes
  wire setup_ph = apb_req.psel & ~apb_req.penable;
  wire wr_commit = apb_req.psel & apb_req.penable & pready & apb_req.pwrite
                 & addr_mapped;
  wire [7:0] wdata = apb_req.pwdata[7:0];

  //////////////////////////////////////////////////////////////////////////
  // read mux; narrow registers sit in the low byte, upper bits zero
  logic [7:0] rd_byte;
  always_comb begin
    if (sel_gpio_en) begin
      rd_byte = gpio_wake_enable_ff;
    end else if (sel_misc_en) begin
      rd_byte = misc_wake_enable_ff;
    end else if (sel_gpio_sts) begin
      rd_byte = gpio_wake_status_ff;
    end else if (sel_misc_sts) begin
      rd_byte = misc_wake_status_ff;
    end else if (sel_global) begin
      rd_byte = {7'h00, global_wake_enable_ff};
    end else begin
      rd_byte = 8'h00; // unmapped reads zero with an error
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // enable register writes; reserved bit never stores, recovery bit per variant
  wire [7:0] misc_wr_mask = HAS_PFR ? PWG_MISC_WR_PFR : PWG_MISC_WR_NOPFR;
  wire [7:0] nxt_gpio_wake_enable = (wr_commit & sel_gpio_en) ? wdata
                                  : gpio_wake_enable_ff;
  wire [7:0] nxt_misc_wake_enable = (wr_commit & sel_misc_en) ? (wdata & misc_wr_mask)
                                  : misc_wake_enable_ff;
  wire       nxt_global_wake_enable = (wr_commit & sel_global) ? wdata[0]
                                    : global_wake_enable_ff;

  // only the standby-power reset reaches these; main power, soft and bus
  // resets are deliberately not wired in so wake setup survives them
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gpio_wake_enable_ff   <= PWG_EN_RST;
      misc_wake_enable_ff   <= PWG_EN_RST;
      global_wake_enable_ff <= PWG_GLOBAL_RST;
    end else begin
      gpio_wake_enable_ff   <= nxt_gpio_wake_enable;
      misc_wake_enable_ff   <= nxt_misc_wake_enable;
      global_wake_enable_ff <= nxt_global_wake_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sticky status, set regardless of enable; set beats a same-cycle clear
  wire [7:0] gpio_clr = (wr_commit & sel_gpio_sts) ? wdata : 8'h00;
  wire [7:0] misc_clr = (wr_commit & sel_misc_sts) ? wdata : 8'h00;
  wire [7:0] misc_evt = wake_event.misc & PWG_MISC_SRC_MASK;
  wire [7:0] nxt_gpio_wake_status = (gpio_wake_status_ff & ~gpio_clr)
                                  | wake_event.gpio;
  wire [7:0] nxt_misc_wake_status = (misc_wake_status_ff & ~misc_clr)
                                  | misc_evt;

  // status lives in the standby domain too
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      gpio_wake_status_ff <= PWG_STS_RST;
      misc_wake_status_ff <= PWG_STS_RST;
    end else begin
      gpio_wake_status_ff <= nxt_gpio_wake_status;
      misc_wake_status_ff <= nxt_misc_wake_status;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-bit gating: pin n of 50..57 on bit n-50, misc sources by position
  logic [7:0] gpio_term; // gated pin terms
  logic [7:0] misc_term; // gated misc terms
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_gate
      assign gpio_term[gi] = gpio_wake_enable_ff[gi]
                           & gpio_wake_status_ff[gi];
      assign misc_term[gi] = misc_wake_enable_ff[gi] & misc_wake_status_ff[gi]
                           & PWG_MISC_SRC_MASK[gi];
    end
  endgenerate

  // the recovery bit is an enable only, never a wake term
  wire any_term     = |{gpio_term, misc_term};
  wire nxt_wake_out_n = ~(global_wake_enable_ff & any_term);

  // wake pin from a flop so it never glitches on the board
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wake_out_n_ff <= 1'b1;
    end else begin
      wake_out_n_ff <= nxt_wake_out_n;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data and error latched in setup, stable through access
  wire [31:0] nxt_prdata  = setup_ph ? {24'h000000, rd_byte} : prdata_ff;
  wire        nxt_pslverr = setup_ph ? ~addr_mapped : pslverr_ff;
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // zero wait states: every access phase completes at once
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = pslverr_ff & apb_req.psel & apb_req.penable;
  assign wake_out_n = wake_out_n_ff;
  assign power_fail_recovery_enable = misc_wake_enable_ff[PWG_MISC_PFR];

  //////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  gpio_write_a: assert property (
    wr_commit && sel_gpio_en |=> gpio_wake_enable_ff == $past(wdata))
    else $error("pin enable write not stored");

  misc_rsvd_zero_a: assert property (
    misc_wake_enable_ff[PWG_MISC_RSVD] == 1'b0)
    else $error("misc reserved bit set");

  enable_hold_a: assert property (
    !(wr_commit && (sel_gpio_en || sel_misc_en)) |=> $stable(gpio_wake_enable_ff)
    && $stable(misc_wake_enable_ff))
    else $error("enable changed without write");

  after_reset_a: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    $fell(reset) |-> gpio_wake_enable_ff == PWG_EN_RST
    && misc_wake_enable_ff == PWG_EN_RST)
    else $error("enables not cleared by standby reset");

  wake_gated_a: assert property (
    global_wake_enable_ff && (gpio_wake_enable_ff & gpio_wake_status_ff) != 8'h00
    |=> !wake_out_n)
    else $error("enabled pending source did not wake");

  no_global_a: assert property (
    !global_wake_enable_ff |=> wake_out_n)
    else $error("wake asserted without global enable");

  disabled_records_a: assert property (
    wake_event.gpio != 8'h00 |=> (gpio_wake_status_ff & $past(wake_event.gpio))
    == $past(wake_event.gpio))
    else $error("pin event not recorded");

  misc_silent_a: assert property (
    (misc_wake_enable_ff & misc_wake_status_ff & PWG_MISC_SRC_MASK) == 8'h00
    && (gpio_wake_enable_ff & gpio_wake_status_ff) == 8'h00 |=> wake_out_n)
    else $error("disabled source drove wake");

  w1c_clear_a: assert property (
    wr_commit && sel_gpio_sts && wake_event.gpio == 8'h00
    |=> (gpio_wake_status_ff & $past(wdata)) == 8'h00
    && gpio_wake_status_ff == ($past(gpio_wake_status_ff) & ~$past(wdata)))
    else $error("status write one did not clear");

  pfr_out_a: assert property (
    power_fail_recovery_enable == (HAS_PFR && misc_wake_enable_ff[PWG_MISC_PFR]))
    else $error("recovery enable mismatch");

  //////////////////////////////////////////////////////////////////////////
  // further checks on storage, sticky status, the wake pin and the bus response; each
  // one but unmapped_err_a and mapped_ok_a sees the bus only through flops and decode
  // that this block drives, so a bench that breaks the bus protocol shows up in the bench checks instead

  // misc enable write stores only the writable bits of the variant;
  // the reserved bit must drop out here or it would read back as set
  misc_write_a: assert property (
    wr_commit && sel_misc_en |=> misc_wake_enable_ff == $past(wdata & misc_wr_mask))
    else $error("misc enable write not stored");

  // recovery bit stores only on variants that carry it;
  // elsewhere it must stay zero whatever software writes
  // so the recovery output never shows a stale one
  pfr_store_a: assert property (
    wr_commit && sel_misc_en
    |=> misc_wake_enable_ff[PWG_MISC_PFR] == (HAS_PFR && $past(wdata[PWG_MISC_PFR])))
    else $error("recovery bit store mismatch");

  // pin enables move only on their own write; no other reset or
  // access may touch them, which is how they ride through the
  // main, soft and bus resets of the wider chip
  gpio_keep_a: assert property (
    !(wr_commit && sel_gpio_en) |=> $stable(gpio_wake_enable_ff))
    else $error("pin enable changed without write");

  // same for the misc enables, recovery bit included
  // a change here without a write would lose wake setup
  misc_keep_a: assert property (
    !(wr_commit && sel_misc_en) |=> $stable(misc_wake_enable_ff))
    else $error("misc enable changed without write");

  // a misc source event always lands in status, enabled or not;
  // software polls these bits even with the enable off
  misc_records_a: assert property (
    misc_evt != 8'h00 |=> (misc_wake_status_ff & $past(misc_evt)) == $past(misc_evt))
    else $error("misc event not recorded");

  // an event in the cycle of a clear write must survive it;
  // losing it would drop a wake that arrived during the clear
  set_wins_a: assert property (
    wr_commit && sel_misc_sts
    |=> (misc_wake_status_ff & $past(misc_evt)) == $past(misc_evt))
    else $error("event lost to same cycle clear");

  // write one clears, write zero leaves the bit alone
  // checked only when no event races the write
  misc_w1c_a: assert property (
    wr_commit && sel_misc_sts && misc_evt == 8'h00
    |=> misc_wake_status_ff == ($past(misc_wake_status_ff) & ~$past(wdata)))
    else $error("misc status clear wrong");

  // with no event and no clear write the pin status holds still;
  // stray writes elsewhere must not disturb sticky bits
  sts_quiet_a: assert property (
    !(wr_commit && sel_gpio_sts) && wake_event.gpio == 8'h00
    |=> $stable(gpio_wake_status_ff))
    else $error("pin status changed on its own");

  // a pending enabled misc source pulls the pin low next cycle
  // mouse, key and power button all take this path
  misc_wake_a: assert property (
    global_wake_enable_ff
    && (misc_wake_enable_ff & misc_wake_status_ff & PWG_MISC_SRC_MASK) != 8'h00
    |=> !wake_out_n)
    else $error("enabled misc source did not wake");

  // the pin is exactly the registered nor of every gated term anded with the global enable;
  // this catches a stuck low pin as well as a missing wake
  wake_exact_a: assert property (
    1'b1 |=> wake_out_n == ~$past(global_wake_enable_ff & any_term))
    else $error("wake pin not the gated or");

  // reserved misc positions never become sticky status
  // so they can never feed a wake term by accident
  sts_rsvd_a: assert property (
    (misc_wake_status_ff & ~PWG_MISC_SRC_MASK) == 8'h00)
    else $error("reserved misc status set");

  // reserved enable bit reads back zero in the access phase
  // whatever was written to it
  rsvd_read_a: assert property (
    setup_ph && sel_misc_en |=> prdata[PWG_MISC_RSVD] == 1'b0)
    else $error("reserved enable bit read as one");

  // unmapped access answers with an error in its access phase;
  // the flag was latched in setup from the same held address
  unmapped_err_a: assert property (
    apb_req.psel && apb_req.penable && !addr_mapped |-> pslverr)
    else $error("unmapped access without error");

  // mapped access never errors; a false error would make
  // software retry or give up on a good register
  mapped_ok_a: assert property (
    apb_req.psel && apb_req.penable && addr_mapped |-> !pslverr)
    else $error("mapped access flagged error");

  // narrow registers leave the upper read bits at zero
  upper_zero_a: assert property (
    prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  // leaving standby reset: no wake, no status, gate closed;
  // a wake right after power up would be a false event
  reset_clear_a: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    $fell(reset) |-> wake_out_n && gpio_wake_status_ff == PWG_STS_RST
    && misc_wake_status_ff == PWG_STS_RST && !global_wake_enable_ff)
    else $error("state not cleared by standby reset");

  // covers for the main scenarios
  cov_misc_c:    cover property (global_wake_enable_ff && misc_term != 8'h00);
  cov_wake_c:    cover property ($fell(wake_out_n));
  cov_clear_c:   cover property (wr_commit && sel_misc_sts ##1 wake_out_n);
  cov_unmap_c:   cover property (pslverr);
  cov_set_clr_c: cover property (wr_commit && sel_gpio_sts && wake_event.gpio != 8'h00);

endmodule : pwg_wake_gate

/* test_pwg_wake_gate.sv */
// self-checking bench for the wake enable gating block
`timescale 1ns/1ps
module test_pwg_wake_gate;
  import pwg_pkg::*;
  typedef struct packed {
    logic       rd;     // read access, data compared
    logic       err;    // expected slave error
    logic [7:0] data;   // expected low byte
    logic       wake_n; // expected wake output
    logic       pfr;    // expected recovery enable output
  } pwg_note_type;
  logic            sys_clk;                                  // 100 MHz clock
  logic            reset;                                    // standby reset
  pwg_apb_req_type apb_req;                                  // apb request
  pwg_event_type   wake_event;                               // source events
  logic [31:0]     prdata;                                   // read data
  logic            pready, pslverr, wake_out_n, power_fail_recovery_enable;
  logic [7:0]      en5, en6, s5, s6;                         // model registers
  logic            glob;                                     // model global enable
  pwg_note_type    notes[$];                                 // expected results
  pwg_note_type    got;                                      // oldest note
  int              bad_count, n_tests, i, j;
  // five mapped registers plus one unmapped word
  logic [7:0] idx_tab [6] = '{PWG_IDX_GPIO_EN, PWG_IDX_MISC_EN, PWG_IDX_GPIO_STS,
                              PWG_IDX_MISC_STS, PWG_IDX_GLOBAL_EN, 8'h3F};

  pwg_wake_gate #(.HAS_PFR(1'b1)) pwg_wake_gate_i (
    .sys_clk(sys_clk), .reset(reset), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wake_event(wake_event), .wake_out_n(wake_out_n),
    .power_fail_recovery_enable(power_fail_recovery_enable));

  //////////////////////////////////////////////////////////////////////////////
  // model of the register file, read value per index
  function automatic logic [7:0] model(input logic [7:0] idx);
    case (idx)
      PWG_IDX_GPIO_EN:   model = en5;
      PWG_IDX_MISC_EN:   model = en6;
      PWG_IDX_GPIO_STS:  model = s5;
      PWG_IDX_MISC_STS:  model = s6;
      PWG_IDX_GLOBAL_EN: model = {7'h00, glob};
      default:           model = 8'h00;
    endcase
  endfunction : model

  // wake is the or of every gated term, qualified by the global enable
  function automatic logic wake_n_exp();
    wake_n_exp = !(glob && (((en5 & s5) | (en6 & s6 & PWG_MISC_SRC_MASK)) != 8'h00));
  endfunction : wake_n_exp

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////////////
  // apb master: note the expectation, then setup, access, wait for pready
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    pwg_note_type n;
    int k;
    n = '{!wr, (idx == 8'h3F), model(idx), wake_n_exp(), en6[7]};
    notes.push_back(n);
    @(posedge sys_clk);
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite  <= wr;
    apb_req.paddr   <= {2'b00, idx, 2'b00};
    apb_req.pwdata  <= {24'($urandom()), wd}; // upper bits must be ignored
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      $display("ERROR pready expected 1 seen %b", pready);
      results();
    end
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    if (wr) begin
      case (idx)
        PWG_IDX_GPIO_EN:   en5 = wd;
        PWG_IDX_MISC_EN:   en6 = wd & PWG_MISC_WR_PFR;
        PWG_IDX_GPIO_STS:  s5 = s5 & ~wd;
        PWG_IDX_MISC_STS:  s6 = s6 & ~wd;
        PWG_IDX_GLOBAL_EN: glob = wd[0];
        default:           ;                             // unmapped, ignored
      endcase
    end
  endtask : apb

  // one-cycle event pulse; status catches it even with the enable off
  task automatic pulse(input pwg_event_type ev);
    @(posedge sys_clk);
    wake_event <= ev;
    @(posedge sys_clk);
    wake_event <= '0;
    s5 = s5 | ev.gpio;
    s6 = s6 | (ev.misc & PWG_MISC_SRC_MASK);
    repeat (2) @(posedge sys_clk);
  endtask : pulse

  task automatic do_reset();
    reset <= 1'b1;
    {en5, en6, s5, s6, glob} = '0;
    repeat (16) @(posedge sys_clk);
    reset <= 1'b0;
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////////
  // monitor: each completed access takes the oldest note
  always @(posedge sys_clk) begin
    if (!reset && apb_req.psel && apb_req.penable && pready) begin
      if (notes.size() == 0) begin
        bad_count++;
        $display("ERROR notes expected entry seen none");
      end else begin
        got = notes.pop_front();
        check("pslverr", 32'(got.err), 32'(pslverr));
        if (got.rd) check("prdata", {24'h000000, got.data}, prdata);
        check("wake_out_n", 32'(got.wake_n), 32'(wake_out_n));
        check("pfr_enable", 32'(got.pfr), 32'(power_fail_recovery_enable));
      end
    end
  end

  // clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // main sequence
  initial begin
    apb_req = '0;
    wake_event = '0;
    bad_count = 0;
    n_tests = 0;
    i = $urandom(17);
    do_reset();
    for (i = 0; i < 6; i++) apb(1'b0, idx_tab[i], 8'h00);
    // random writes everywhere, unmapped included, then read back
    repeat (3) begin
      for (i = 0; i < 6; i++) apb(1'b1, idx_tab[i], 8'($urandom()));
      for (i = 0; i < 6; i++) apb(1'b0, idx_tab[i], 8'h00);
    end
    // each source alone, then random mixes of sources
    for (i = 0; i < 24; i++) begin
      apb(1'b1, PWG_IDX_GPIO_EN, 8'($urandom()));
      apb(1'b1, PWG_IDX_MISC_EN, 8'($urandom()));
      apb(1'b1, PWG_IDX_GLOBAL_EN, {7'h00, i[1:0] != 2'b00});
      pulse(pwg_event_type'((i < 16) ? (16'h0001 << i) : 16'($urandom())));
      for (j = 2; j < 4; j++) apb(1'b1, idx_tab[j], 8'h00);
      for (j = 0; j < 5; j++) apb(1'b0, idx_tab[j], 8'h00);
      for (j = 2; j < 4; j++) apb(1'b1, idx_tab[j], 8'hFF);
    end
    // leave state set, reset in mid-run, all back to zero
    apb(1'b1, PWG_IDX_MISC_EN, 8'hFF);
    do_reset();
    for (i = 0; i < 5; i++) apb(1'b0, idx_tab[i], 8'h00);
    repeat (2) @(posedge sys_clk);
    check("notes_left", 32'h00000000, 32'(notes.size()));
    results();
  end
endmodule : test_pwg_wake_gate
